//--- design/acrr_adc_ctrl.v
// Converter control, clock prescaler and result registers behind an AHB-Lite slave
// Notes on behaviour
// - Done flag set per conversion, cleared by result read
// - Interrupt enable set: done flag never set
// - Interrupt enable raises request at conversion end
// - Result read or control write drops request
// - Continuous bit converts back to back
// - Single mode: one conversion per control write
// - Five-bit channel code, zero to seven external
// - Codes 1D and 1E route references
// - All-ones channel powers converter off
// - Unused channel codes give undefined results
// - Left mode: bits 9..2 high, 1..0 low top
// - Right mode: two MSBs high, eight low
// - Signed left mode inverts result top bit
// - Ten-bit modes: high read freezes low
// - Truncation: bits 9..2 low, no interlock
// - Prescale divides by 1,2,4,8,16
// - Clock select one bus, zero crystal
// - Justification codes; reset selects right justified
// - Result registers update per completed conversion, except while the low half is held
// - Conversion takes 16 to 17 converter clocks
// - Continuous results overwrite unread ones unless the low half is held
// - Core codes span reference low to high
`timescale 1ns/1ns
`include "acrr_regs.vh"

module acrr_adc_ctrl
(
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst_b,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// Converter input clock sources
	input  wire        crystalOscillatorClock,
	// Analog core
	output reg         coreStart,
	output reg  [4:0]  coreChannel,
	output reg         coreClock,
	output reg         corePowerOff,
	output reg         coreSelRefHigh,
	output reg         coreSelRefLow,
	input  wire        coreDone,
	input  wire [9:0]  coreResult,
	// Interrupt request
	output reg         conversionIrq
);

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	reg        doneFlag_reg;
	reg        irqEnable_reg;
	reg        continuous_reg;
	reg  [4:0] channel_reg;
	reg  [2:0] prescale_reg;
	reg        clockSource_reg;
	reg  [1:0] justify_reg;
	reg  [7:0] resultHigh_reg;
	reg  [7:0] resultLow_reg;
	reg        frozen_reg;
	reg        busy_reg;
	reg        pending_reg;
	reg  [4:0] cycleCount_reg;
	reg  [3:0] divCount_reg;
	reg  [2:0] xtalSync_reg;
	reg        xtalLevel_reg;
	reg  [2:0] doneSync_reg;
	reg        doneLevel_reg;
	reg        apValid_reg;
	reg        apWrite_reg;
	reg  [7:0] apAddr_reg;
	reg  [31:0] rdata_reg;

	// ------------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------------
	wire       apTake   = hsel && hready && htrans[1];
	wire       wrCtrl   = apValid_reg && apWrite_reg && (apAddr_reg == `ACRR_OFF_CTRL);
	wire       wrClk    = apValid_reg && apWrite_reg && (apAddr_reg == `ACRR_OFF_CLKCFG);
	wire       rdHigh   = apTake && !hwrite && (haddr[7:0] == `ACRR_OFF_RESH);
	wire       rdLow    = apTake && !hwrite && (haddr[7:0] == `ACRR_OFF_RESL);
	wire       tenBit   = (justify_reg != `ACRR_MODE_TRUNC);

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_reg;

	// ------------------------------------------------------------------------
	// Input clock edge generation from sampled sources
	// ------------------------------------------------------------------------
	wire xtalRise = (xtalSync_reg[2] == xtalSync_reg[1]) && xtalSync_reg[1] && !xtalLevel_reg;
	wire srcTick  = clockSource_reg ? 1'b1 : xtalRise;

	function [3:0] divLimit;
		input [2:0] code;
		begin
			case (code)
				3'h0: divLimit = 4'h0;
				3'h1: divLimit = 4'h1;
				3'h2: divLimit = 4'h3;
				3'h3: divLimit = 4'h7;
				default: divLimit = 4'hF;
			endcase
		end
	endfunction

	// Converter clock toggles once per divided period, so only a wrap with the clock low marks a rising edge
	wire divWrap  = srcTick && (divCount_reg >= divLimit(prescale_reg));
	wire coreDoneRise = (doneSync_reg[2] == doneSync_reg[1]) && doneSync_reg[1] && !doneLevel_reg;

	// ------------------------------------------------------------------------
	// Result formatting
	// ------------------------------------------------------------------------
	reg [7:0] fmtHigh;
	reg [7:0] fmtLow;
	always @*
	begin
		case (justify_reg)
			`ACRR_MODE_RIGHT:
			begin
				fmtHigh = {6'h00, coreResult[9:8]};
				fmtLow  = coreResult[7:0];
			end
			`ACRR_MODE_LEFT:
			begin
				fmtHigh = coreResult[9:2];
				fmtLow  = {coreResult[1:0], 6'h00};
			end
			`ACRR_MODE_SLEFT:
			begin
				fmtHigh = {~coreResult[9], coreResult[8:2]};
				fmtLow  = {coreResult[1:0], 6'h00};
			end
			default:
			begin
				fmtHigh = 8'h00;
				fmtLow  = coreResult[9:2];
			end
		endcase
	end

	// Discard results while low half is held
	wire storeResult = coreDoneRise && busy_reg && !(tenBit && (frozen_reg || rdHigh));
	wire convEnd     = coreDoneRise && busy_reg;

	// ------------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------------
	localparam [7:0] CTRL_RST   = `ACRR_CTRL_RST;
	localparam [7:0] CLKCFG_RST = `ACRR_CLKCFG_RST;

	// ------------------------------------------------------------------------
	// Bus capture and read data
	// ------------------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			apValid_reg <= 1'b0;
			apWrite_reg <= 1'b0;
			apAddr_reg  <= 8'h00;
			rdata_reg   <= 32'h0000_0000;
		end
		else
		begin
			apValid_reg <= apTake;
			apWrite_reg <= hwrite;
			apAddr_reg  <= haddr[7:0];
			if (apTake && !hwrite)
			begin
				case (haddr[7:0])
					`ACRR_OFF_CTRL:
						rdata_reg <= {24'h000000, doneFlag_reg && !irqEnable_reg, irqEnable_reg,
							continuous_reg, channel_reg};
					`ACRR_OFF_RESH:   rdata_reg <= {24'h000000, resultHigh_reg};
					`ACRR_OFF_RESL:   rdata_reg <= {24'h000000, resultLow_reg};
					`ACRR_OFF_CLKCFG:
						rdata_reg <= {24'h000000, prescale_reg, clockSource_reg, justify_reg, 2'h0};
					default:          rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			xtalSync_reg  <= 3'h0;
			xtalLevel_reg <= 1'b0;
			doneSync_reg  <= 3'h0;
			doneLevel_reg <= 1'b0;
		end
		else
		begin
			xtalSync_reg <= {xtalSync_reg[1:0], crystalOscillatorClock};
			if (xtalSync_reg[2] == xtalSync_reg[1])
				xtalLevel_reg <= xtalSync_reg[1];
			doneSync_reg <= {doneSync_reg[1:0], coreDone};
			if (doneSync_reg[2] == doneSync_reg[1])
				doneLevel_reg <= doneSync_reg[1];
		end
	end

	// ------------------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			divCount_reg <= 4'h0;
			coreClock    <= 1'b0;
		end
		else
		begin
			if (divWrap)
				divCount_reg <= 4'h0;
			else if (srcTick)
				divCount_reg <= divCount_reg + 4'h1;
			if (divWrap)
				coreClock <= ~coreClock;
		end
	end

	// ------------------------------------------------------------------------
	// Configuration registers; done flag position is ignored on write
	// ------------------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irqEnable_reg   <= CTRL_RST[`ACRR_BIT_IEN];
			continuous_reg  <= CTRL_RST[`ACRR_BIT_CONT];
			channel_reg     <= CTRL_RST[`ACRR_CH_MSB:`ACRR_CH_LSB];
			prescale_reg    <= CLKCFG_RST[`ACRR_DIV_MSB:`ACRR_DIV_LSB];
			clockSource_reg <= CLKCFG_RST[`ACRR_BIT_ICLK];
			justify_reg     <= CLKCFG_RST[`ACRR_MODE_MSB:`ACRR_MODE_LSB];
		end
		else
		begin
			if (wrCtrl)
			begin
				irqEnable_reg  <= hwdata[`ACRR_BIT_IEN];
				continuous_reg <= hwdata[`ACRR_BIT_CONT];
				channel_reg    <= hwdata[`ACRR_CH_MSB:`ACRR_CH_LSB];
			end
			if (wrClk)
			begin
				prescale_reg    <= hwdata[`ACRR_DIV_MSB:`ACRR_DIV_LSB];
				clockSource_reg <= hwdata[`ACRR_BIT_ICLK];
				justify_reg     <= hwdata[`ACRR_MODE_MSB:`ACRR_MODE_LSB];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Channel routing to core
	// ------------------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			coreChannel    <= `ACRR_CH_OFF;
			corePowerOff   <= 1'b1;
			coreSelRefHigh <= 1'b0;
			coreSelRefLow  <= 1'b0;
		end
		else
		begin
			coreChannel    <= channel_reg;
			corePowerOff   <= (channel_reg == `ACRR_CH_OFF);
			coreSelRefHigh <= (channel_reg == `ACRR_CH_REFH);
			coreSelRefLow  <= (channel_reg == `ACRR_CH_REFL);
		end
	end

	// ------------------------------------------------------------------------
	// Result registers and interlock
	// ------------------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			frozen_reg     <= 1'b0;
			resultHigh_reg <= 8'h00;
			resultLow_reg  <= 8'h00;
		end
		else
		begin
			if (tenBit && rdHigh)
				frozen_reg <= 1'b1;
			else if (rdLow || !tenBit)
				frozen_reg <= 1'b0;
			if (storeResult)
			begin
				resultHigh_reg <= fmtHigh;
				resultLow_reg  <= fmtLow;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Done flag and interrupt request; set beats clear
	// ------------------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			doneFlag_reg  <= 1'b0;
			conversionIrq <= 1'b0;
		end
		else
		begin
			if (convEnd && !irqEnable_reg)
				doneFlag_reg <= 1'b1;
			else if (rdHigh || rdLow)
				doneFlag_reg <= 1'b0;
			if (convEnd && irqEnable_reg)
				conversionIrq <= 1'b1;
			else if (rdHigh || rdLow || wrCtrl)
				conversionIrq <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Conversion sequencing, counted in converter clock edges
	// ------------------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			coreStart      <= 1'b0;
			busy_reg       <= 1'b0;
			pending_reg    <= 1'b0;
			cycleCount_reg <= 5'h00;
		end
		else
		begin
			coreStart <= 1'b0;
			if (wrCtrl)
			begin
				busy_reg    <= 1'b0;
				pending_reg <= (hwdata[`ACRR_CH_MSB:`ACRR_CH_LSB] != `ACRR_CH_OFF);
			end
			else if (pending_reg && divWrap && !coreClock)
			begin
				pending_reg    <= 1'b0;
				busy_reg       <= 1'b1;
				coreStart      <= 1'b1;
				cycleCount_reg <= 5'h00;
			end
			else if (busy_reg)
			begin
				if (divWrap && !coreClock && cycleCount_reg != 5'h1F)
					cycleCount_reg <= cycleCount_reg + 5'h01;
				if (convEnd)
				begin
					busy_reg    <= 1'b0;
					pending_reg <= continuous_reg && !corePowerOff;
				end
			end
		end
	end

endmodule

//--- pkg/acrr_regs.vh
// Register offsets, fields, reset values and codes of the converter control block
`ifndef ACRR_REGS_VH
`define ACRR_REGS_VH

// ----------------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------------
`define ACRR_OFF_CTRL    8'h00
`define ACRR_OFF_RESH    8'h04
`define ACRR_OFF_RESL    8'h08
`define ACRR_OFF_CLKCFG  8'h0C

// ----------------------------------------------------------------------------
// Control/status fields
// ----------------------------------------------------------------------------
`define ACRR_BIT_DONE    7
`define ACRR_BIT_IEN     6
`define ACRR_BIT_CONT    5
`define ACRR_CH_MSB      4
`define ACRR_CH_LSB      0
`define ACRR_CTRL_RST    8'h1F

// ----------------------------------------------------------------------------
// Clock configuration fields
// ----------------------------------------------------------------------------
`define ACRR_DIV_MSB     7
`define ACRR_DIV_LSB     5
`define ACRR_BIT_ICLK    4
`define ACRR_MODE_MSB    3
`define ACRR_MODE_LSB    2
`define ACRR_CLKCFG_RST  8'h04

// ----------------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------------
`define ACRR_MODE_TRUNC  2'h0
`define ACRR_MODE_RIGHT  2'h1
`define ACRR_MODE_LEFT   2'h2
`define ACRR_MODE_SLEFT  2'h3
`define ACRR_CH_REFH     5'h1D
`define ACRR_CH_REFL     5'h1E
`define ACRR_CH_OFF      5'h1F
`define ACRR_CONV_MIN    5'h10

`endif

//--- tb/acrr_adc_ctrl_checker.sv
// Concurrent checks on the converter control block ports
`timescale 1ns/1ns
module acrr_adc_ctrl_checker
(
	// Clock and reset
	input wire        sys_clk,
	input wire        rst_b,
	// Bus
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire [31:0] hwdata,
	input wire [31:0] hrdata,
	// Core and interrupt
	input wire        coreStart,
	input wire [4:0]  coreChannel,
	input wire        corePowerOff,
	input wire        coreSelRefHigh,
	input wire        coreSelRefLow,
	input wire        conversionIrq
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_b);
// ----------------------------------------------------------------------------
// Bus events
// ----------------------------------------------------------------------------
sequence addrPh; hsel && hready && htrans[1]; endsequence
sequence ctrlWr; addrPh ##0 (hwrite && haddr[7:0] == 8'h00); endsequence
sequence resRd; addrPh ##0 (!hwrite && (haddr[7:0] == 8'h04 || haddr[7:0] == 8'h08)); endsequence
sequence offWr; ctrlWr ##1 (hwdata[4:0] == 5'h1F); endsequence
chk_off_code: assert property
	(corePowerOff == (coreChannel == 5'h1F)) else $error("power off level wrong");
chk_ref_high: assert property
	(coreSelRefHigh == (coreChannel == 5'h1D)) else $error("high reference select wrong");
chk_ref_low: assert property
	(coreSelRefLow == (coreChannel == 5'h1E)) else $error("low reference select wrong");
chk_start_on: assert property
	(coreStart |-> !corePowerOff) else $error("start while powered off");
chk_start_pulse: assert property
	(coreStart |=> !coreStart) else $error("start pulse too long");
chk_off_idle: assert property
	(offWr |-> ##2 !coreStart [*8]) else $error("start after power off write");
chk_irq_write: assert property
	(ctrlWr |-> ##2 !conversionIrq) else $error("irq kept after control write");
chk_irq_read: assert property
	(resRd |-> ##1 !conversionIrq) else $error("irq kept after result read");
chk_upper_zero: assert property
	(hrdata[31:8] == 24'h0) else $error("unused read bits set");
endmodule
bind acrr_adc_ctrl acrr_adc_ctrl_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.hrdata(hrdata), .coreStart(coreStart), .coreChannel(coreChannel),
	.corePowerOff(corePowerOff), .coreSelRefHigh(coreSelRefHigh),
	.coreSelRefLow(coreSelRefLow), .conversionIrq(conversionIrq));

//--- tb/test_adc_control_result_regs.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ns
`include "acrr_regs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module test_adc_control_result_regs;
typedef struct {logic [1:0] m; logic [9:0] r; logic [7:0] h; logic [7:0] l;} acrr_row_t;
logic        sys_clk = 0;
logic        rst_b = 0;
logic        hsel = 0;
logic [31:0] haddr = 0;
logic [1:0]  htrans = 0;
logic        hwrite = 0;
logic [31:0] hwdata = 0;
logic        xtalClk = 0;
logic        coreDone = 0;
logic [9:0]  coreResult = 0;
logic [31:0] rd;
wire  [31:0] hrdata;
wire  [4:0]  coreChannel;
wire         hreadyout, hresp, coreStart, coreClock, corePowerOff, refHi, refLo, irq;
int          errors = 0, cmp_count = 0, n, p, p0, starts = 0, used = 0;
logic [7:0]  ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
logic [7:0]  re[5] = '{8'h1F, 8'h00, 8'h00, 8'h04, 8'h00};
acrr_row_t   rows[6] = '{'{2'h0, 10'h2B5, 8'h00, 8'hAD}, '{2'h1, 10'h2B5, 8'h02, 8'hB5},
	'{2'h2, 10'h2B5, 8'hAD, 8'h40}, '{2'h3, 10'h2B5, 8'h2D, 8'h40},
	'{2'h1, 10'h3FF, 8'h03, 8'hFF}, '{2'h3, 10'h000, 8'h80, 8'h00}};
always #4 sys_clk = ~sys_clk;
always #32 xtalClk = ~xtalClk;
always @(posedge sys_clk)
	if (coreStart === 1'b1)
		starts <= starts + 1;
acrr_adc_ctrl dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .crystalOscillatorClock(xtalClk),
	.coreStart(coreStart), .coreChannel(coreChannel), .coreClock(coreClock),
	.corePowerOff(corePowerOff), .coreSelRefHigh(refHi), .coreSelRefLow(refLo),
	.coreDone(coreDone), .coreResult(coreResult), .conversionIrq(irq));
// ----------------------------------------------------------------------------
// Tasks
// ----------------------------------------------------------------------------
task automatic end_sim;
	$display("errors %0d comparisons %0d", errors, cmp_count);
	if (errors == 0 && cmp_count > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
task automatic wt;
	n = 0;
	@(posedge sys_clk);
	while (hreadyout !== 1'b1 && n < 200)
	begin
		n++;
		@(posedge sys_clk);
	end
	if (n == 200)
	begin
		errors++;
		end_sim;
	end
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
	hsel <= 1'b1;
	hwrite <= w;
	haddr <= {24'h0, a};
	htrans <= 2'h2;
	wt;
	htrans <= 2'h0;
	hwdata <= d;
	wt;
	rd = hrdata;
endtask
task automatic conv(input logic [9:0] r);
	n = 0;
	while (starts == used && n < 200)
	begin
		n++;
		@(posedge sys_clk);
	end
	if (n == 200)
	begin
		errors++;
		end_sim;
	end
	used++;
	repeat (3) @(posedge sys_clk);
	coreResult <= r;
	coreDone <= 1'b1;
	repeat (8) @(posedge sys_clk);
	coreDone <= 1'b0;
	repeat (2) @(posedge sys_clk);
endtask
task automatic per(output int q);
	int k;
	int s;
	logic c;
	k = 0;
	s = 0;
	q = 0;
	c = coreClock;
	for (int i = 0; i < 300; i++)
	begin
		@(posedge sys_clk);
		if (coreClock === 1'b1 && c === 1'b0)
			k++;
		if (coreClock === 1'b1 && c === 1'b0 && k == 2)
			s = i;
		if (coreClock === 1'b1 && c === 1'b0 && k == 3)
			q = i - s;
		c = coreClock;
	end
endtask
// ----------------------------------------------------------------------------
// Main sequence
// ----------------------------------------------------------------------------
initial
begin
	repeat (2) @(posedge sys_clk);
	rst_b <= 1'b1;
	@(posedge sys_clk);
	for (int i = 0; i < 5; i++)
	begin
		bus(0, ra[i], 0);
		`CHK(rd[7:0], re[i])
	end
	bus(1, `ACRR_OFF_CTRL, 0);
	conv(10'h000);
	foreach (rows[i])
	begin
		bus(1, `ACRR_OFF_CLKCFG, {27'h0, 1'b1, rows[i].m, 2'h0});
		bus(1, `ACRR_OFF_CTRL, 32'(i));
		conv(rows[i].r);
		`CHK(coreChannel, 5'(i))
		bus(0, `ACRR_OFF_CTRL, 0);
		`CHK(rd[7:0], 8'h80 | 8'(i))
		bus(0, `ACRR_OFF_RESH, 0);
		`CHK(rd[7:0], rows[i].h)
		bus(0, `ACRR_OFF_RESL, 0);
		`CHK(rd[7:0], rows[i].l)
		bus(0, `ACRR_OFF_CTRL, 0);
		`CHK(rd[7:0], 8'(i))
	end
	p = 0;
	repeat (60)
	begin
		@(posedge sys_clk);
		p = p + (coreStart === 1'b1);
	end
	`CHK(p, 0)
	for (int c = 0; c < 8; c++)
	begin
		bus(1, `ACRR_OFF_CLKCFG, {24'h0, 3'(c), 5'h14});
		per(p);
		if (c == 0)
			p0 = p;
		`CHK(p > 0, 1'b1)
		`CHK(p, p0 * (c > 3 ? 16 : 1 << c))
	end
	bus(1, `ACRR_OFF_CTRL, 32'h42);
	conv(10'h001);
	`CHK(irq, 1'b1)
	bus(0, `ACRR_OFF_CTRL, 0);
	`CHK(rd[7:0], 8'h42)
	bus(1, `ACRR_OFF_CTRL, 32'h42);
	@(posedge sys_clk);
	`CHK(irq, 1'b0)
	conv(10'h002);
	`CHK(irq, 1'b1)
	bus(0, `ACRR_OFF_RESL, 0);
	`CHK(rd[7:0], 8'h02)
	@(posedge sys_clk);
	`CHK(irq, 1'b0)
	bus(1, `ACRR_OFF_CLKCFG, 32'h18);
	bus(1, `ACRR_OFF_CTRL, 0);
	conv(10'h155);
	bus(0, `ACRR_OFF_RESH, 0);
	`CHK(rd[7:0], 8'h55)
	bus(1, `ACRR_OFF_CTRL, 0);
	conv(10'h2AA);
	bus(0, `ACRR_OFF_RESH, 0);
	`CHK(rd[7:0], 8'h55)
	bus(0, `ACRR_OFF_RESL, 0);
	`CHK(rd[7:0], 8'h40)
	bus(1, `ACRR_OFF_CLKCFG, 32'h14);
	bus(1, `ACRR_OFF_CTRL, 32'h20);
	conv(10'h3FF);
	conv(10'h001);
	bus(0, `ACRR_OFF_RESL, 0);
	`CHK(rd[7:0], 8'h01)
	bus(1, `ACRR_OFF_CTRL, 32'h1D);
	repeat (2) @(posedge sys_clk);
	`CHK(refHi, 1'b1)
	bus(1, `ACRR_OFF_CTRL, 32'h1E);
	repeat (2) @(posedge sys_clk);
	`CHK(refLo, 1'b1)
	bus(1, `ACRR_OFF_CTRL, 32'h1F);
	repeat (2) @(posedge sys_clk);
	`CHK(corePowerOff, 1'b1)
	end_sim;
end
endmodule
